/* File: rtl/ea_gen_map.vh */
// Purpose: Constants for the effective address generator.
// Assumes: Included once per module that needs the encodings.
// Notes:   Mode, class and operation codes are internal encodings.
`ifndef EA_GEN_MAP_VH
`define EA_GEN_MAP_VH

`define MODE_REG_DIRECT    4'h0
`define MODE_REG_INDIRECT  4'h1
`define MODE_DISP16        4'h2
`define MODE_POST_INC      4'h3
`define MODE_PRE_DEC       4'h4
`define MODE_ABS8          4'h5
`define MODE_ABS16         4'h6
`define MODE_IMM8          4'h7
`define MODE_IMM16         4'h8
`define MODE_PC_REL        4'h9
`define MODE_MEM_INDIRECT  4'hA
`define MODE_STACK_PUSH    4'hB
`define MODE_STACK_POP     4'hC

`define OP_MOVE_BYTE       5'h00
`define OP_MOVE_WORD       5'h01
`define OP_ADD_WORD        5'h02
`define OP_SUB_WORD        5'h03
`define OP_CMP_WORD        5'h04
`define OP_ADD_SMALL_CONST 5'h05
`define OP_SUB_SMALL_CONST 5'h06
`define OP_MUL_UNSIGNED    5'h07
`define OP_DIV_UNSIGNED    5'h08
`define OP_ADD_BYTE        5'h09
`define OP_ADD_WITH_CARRY  5'h0A
`define OP_SUB_WITH_CARRY  5'h0B
`define OP_CMP_BYTE        5'h0C
`define OP_AND_BYTE        5'h0D
`define OP_OR_BYTE         5'h0E
`define OP_XOR_BYTE        5'h0F
`define OP_OTHER_ALU       5'h10
`define OP_BIT_SET         5'h11
`define OP_BIT_CLEAR       5'h12
`define OP_BIT_INVERT      5'h13
`define OP_BIT_TEST        5'h14
`define OP_BIT_OTHER       5'h15
`define OP_JUMP            5'h16
`define OP_JUMP_SUBROUTINE 5'h17
`define OP_BRANCH_COND     5'h18
`define OP_BRANCH_SUB      5'h19
`define OP_CCR_PUSH        5'h1A
`define OP_CCR_POP         5'h1B

`define ABS8_PAGE          8'hFF
`define INDIRECT_PAGE      8'h00

`define ST_IDLE            2'h0
`define ST_IND_READ        2'h1
`define ST_IND_DONE        2'h2

`endif

/* File: rtl/ea_word_align.v */
// Purpose: Word alignment of the address for one memory access.
// Assumes: Most significant byte at the even address.
// Notes:   Purely combinational.
`timescale 1ns/1ns
module ea_word_align (
    input  wire [15:0] addr_i,
    input  wire        word_i,
    output wire [15:0] addr_o
);
    // Word accesses drop bit 0 so an odd address reaches the preceding even one.
    assign addr_o = word_i ? {addr_i[15:1], 1'b0} : addr_i;
endmodule

/* File: rtl/effective_address_gen.v */
// Purpose: Operand and branch effective address generation for the core.
// Assumes: Decode supplies class, mode and instruction bytes in one request.
// Notes:   Register file lives outside; write-back values are handed back.
// Functional notes
// - Condition code push duplicates flags in both bytes.
// - Condition code pop takes upper byte only.
// - Register direct selects byte or word register.
// - Word register operands only for listed instructions.
// - Register indirect uses register as address.
// - Displacement add_small_const bytes 3-4; move only.
// - Post-increment loads, then add_small_const one or two.
// - Pre-decrement stores, subtract first, keep result.
// - Eight-bit absolute forces upper byte ones.
// - Absolute forms restricted to listed instructions.
// - Immediate from byte 2 or bytes 3-4.
// - Small constant ops imply one or two.
// - Bit number is three-bit immediate field.
// - Relative branch add_small_const sign-extended displacement.
// - Memory indirect reads low-page word target.
// - Memory indirect only for jumps.
// - Odd word addresses cleared to even.
// - ALU uses register direct, some immediate.
// - Moves allow all but relative, memory indirect and stack modes; 16-bit immediate is word only, eight-bit absolute byte only.
// - Bit ops use direct, indirect, short absolute, eight-bit immediate.
// - Word high byte sits at even address.
`timescale 1ns/1ns
`include "ea_gen_map.vh"
module effective_address_gen (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        req_i,
    input  wire [4:0]  op_i,
    input  wire [3:0]  mode_i,
    input  wire        is_load_i,
    input  wire        bit_from_reg_i,
    input  wire        bit_in_byte4_i,
    input  wire        small_two_i,
    input  wire [7:0]  byte2_i,
    input  wire [7:0]  byte3_i,
    input  wire [7:0]  byte4_i,
    input  wire [15:0] reg_value_i,
    input  wire [15:0] next_pc_i,
    input  wire [7:0]  ccr_i,
    input  wire [15:0] stack_pointer_reg_i,
    input  wire        mem_ready_i,
    input  wire [15:0] mem_rdata_i,
    output wire        busy_o,
    output reg         done_o,
    output reg         undefined_o,
    output reg         mem_req_o,
    output reg         mem_write_o,
    output reg         mem_word_o,
    output reg  [15:0] mem_addr_o,
    output reg  [15:0] mem_wdata_o,
    output reg         use_reg_o,
    output reg         reg_word_o,
    output reg         imm_valid_o,
    output reg  [15:0] imm_o,
    output reg  [2:0]  bit_num_o,
    output reg         bit_num_from_reg_o,
    output reg         branch_o,
    output reg  [15:0] target_o,
    output reg         reg_wb_o,
    output reg  [15:0] reg_wb_value_o,
    output reg         ccr_load_o,
    output reg  [7:0]  ccr_o
);
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg         legal;
    reg         word_op;
    reg         is_move;
    reg         is_alu_imm;
    reg         is_alu;
    reg         is_bit;
    reg         is_jump;
    reg  [15:0] raw_addr;
    wire [15:0] aligned_addr;
    wire [15:0] disp_word;
    wire [15:0] step;
    wire [15:0] rel_target;

    assign disp_word  = {byte3_i, byte4_i};
    assign step       = word_op ? 16'h0002 : 16'h0001;
    assign rel_target = next_pc_i + {{8{byte2_i[7]}}, byte2_i};
    assign busy_o     = (state != `ST_IDLE);

    always @* begin
        is_move    = (op_i == `OP_MOVE_BYTE) || (op_i == `OP_MOVE_WORD);
        is_jump    = (op_i == `OP_JUMP) || (op_i == `OP_JUMP_SUBROUTINE);
        is_bit     = (op_i >= `OP_BIT_SET) && (op_i <= `OP_BIT_OTHER);
        is_alu     = (op_i >= `OP_ADD_WORD) && (op_i <= `OP_OTHER_ALU);
        is_alu_imm = (op_i >= `OP_ADD_BYTE) && (op_i <= `OP_XOR_BYTE);
        word_op    = (op_i >= `OP_MOVE_WORD) && (op_i <= `OP_DIV_UNSIGNED);
        case (mode_i)
            `MODE_REG_DIRECT:   legal = is_move || is_alu || is_bit;
            `MODE_REG_INDIRECT: legal = is_move || is_bit;
            `MODE_DISP16:       legal = is_move;
            `MODE_POST_INC:     legal = is_move && is_load_i;
            `MODE_PRE_DEC:      legal = is_move && !is_load_i;
            `MODE_ABS8:         legal = (op_i == `OP_MOVE_BYTE) || is_bit;
            `MODE_ABS16:        legal = is_move || is_jump;
            `MODE_IMM8:         legal = is_move || is_alu_imm || is_bit;
            `MODE_IMM16:        legal = (op_i == `OP_MOVE_WORD);
            `MODE_PC_REL:       legal = (op_i == `OP_BRANCH_COND) ||
                                        (op_i == `OP_BRANCH_SUB);
            `MODE_MEM_INDIRECT: legal = is_jump;
            `MODE_STACK_PUSH:   legal = (op_i == `OP_CCR_PUSH);
            `MODE_STACK_POP:    legal = (op_i == `OP_CCR_POP);
            default:            legal = 1'b0;
        endcase
        // Small constant ops carry their operand implicitly.
        if ((op_i == `OP_ADD_SMALL_CONST) || (op_i == `OP_SUB_SMALL_CONST)) begin
            legal = (mode_i == `MODE_REG_DIRECT);
        end
        case (mode_i)
            `MODE_DISP16:       raw_addr = reg_value_i + disp_word;
            `MODE_PRE_DEC:      raw_addr = reg_value_i - step;
            `MODE_ABS8:         raw_addr = {`ABS8_PAGE, byte2_i};
            `MODE_ABS16:        raw_addr = disp_word;
            `MODE_MEM_INDIRECT: raw_addr = {`INDIRECT_PAGE, byte2_i};
            `MODE_STACK_PUSH:   raw_addr = stack_pointer_reg_i - 16'h0002;
            `MODE_STACK_POP:    raw_addr = stack_pointer_reg_i;
            default:            raw_addr = reg_value_i;
        endcase
    end

    // Memory indirect and stack traffic is always a word.
    ea_word_align u_align (
        .addr_i (raw_addr),
        .word_i (word_op || (mode_i == `MODE_MEM_INDIRECT) ||
                 (mode_i == `MODE_STACK_PUSH) || (mode_i == `MODE_STACK_POP)),
        .addr_o (aligned_addr)
    );

    always @* begin
        next_state = state;
        case (state)
            `ST_IDLE: begin
                if (req_i && legal && mode_i == `MODE_MEM_INDIRECT) begin
                    next_state = `ST_IND_READ;
                end
            end
            `ST_IND_READ: begin
                if (mem_ready_i) begin
                    next_state = `ST_IND_DONE;
                end
            end
            `ST_IND_DONE: next_state = `ST_IDLE;
            default:      next_state = `ST_IDLE;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state              <= `ST_IDLE;
            done_o             <= 1'b0;
            undefined_o        <= 1'b0;
            mem_req_o          <= 1'b0;
            mem_write_o        <= 1'b0;
            mem_word_o         <= 1'b0;
            mem_addr_o         <= 16'h0000;
            mem_wdata_o        <= 16'h0000;
            use_reg_o          <= 1'b0;
            reg_word_o         <= 1'b0;
            imm_valid_o        <= 1'b0;
            imm_o              <= 16'h0000;
            bit_num_o          <= 3'h0;
            bit_num_from_reg_o <= 1'b0;
            branch_o           <= 1'b0;
            target_o           <= 16'h0000;
            reg_wb_o           <= 1'b0;
            reg_wb_value_o     <= 16'h0000;
            ccr_load_o         <= 1'b0;
            ccr_o              <= 8'h00;
        end else begin
            state       <= next_state;
            done_o      <= 1'b0;
            undefined_o <= 1'b0;
            branch_o    <= 1'b0;
            reg_wb_o    <= 1'b0;
            ccr_load_o  <= 1'b0;
            use_reg_o   <= 1'b0;
            imm_valid_o <= 1'b0;
            if (state == `ST_IDLE) begin
                mem_req_o <= 1'b0;
            end
            if (state == `ST_IDLE && req_i) begin
                if (!legal) begin
                    undefined_o <= 1'b1;
                    done_o      <= 1'b1;
                end else begin
                    mem_word_o  <= word_op;
                    mem_addr_o  <= aligned_addr;
                    mem_write_o <= 1'b0;
                    reg_word_o  <= word_op;
                    // Bit number sits in byte 2 or byte 4, bits 6:4.
                    bit_num_o   <= bit_in_byte4_i ? byte4_i[6:4] : byte2_i[6:4];
                    bit_num_from_reg_o <= bit_from_reg_i && is_bit &&
                                          (op_i <= `OP_BIT_TEST);
                    done_o      <= (mode_i != `MODE_MEM_INDIRECT);
                    case (mode_i)
                        `MODE_REG_DIRECT: begin
                            use_reg_o <= 1'b1;
                            if ((op_i == `OP_ADD_SMALL_CONST) ||
                                (op_i == `OP_SUB_SMALL_CONST)) begin
                                imm_valid_o <= 1'b1;
                                imm_o <= small_two_i ? 16'h0002 : 16'h0001;
                            end
                        end
                        `MODE_IMM8: begin
                            imm_valid_o <= 1'b1;
                            imm_o       <= {8'h00, byte2_i};
                        end
                        `MODE_IMM16: begin
                            imm_valid_o <= 1'b1;
                            imm_o       <= disp_word;
                        end
                        `MODE_PC_REL: begin
                            branch_o <= 1'b1;
                            target_o <= {rel_target[15:1], 1'b0};
                        end
                        `MODE_ABS16: begin
                            if (is_jump) begin
                                branch_o <= 1'b1;
                                target_o <= {disp_word[15:1], 1'b0};
                            end else begin
                                mem_req_o   <= 1'b1;
                                mem_write_o <= !is_load_i;
                            end
                        end
                        `MODE_MEM_INDIRECT: begin
                            mem_req_o  <= 1'b1;
                            mem_word_o <= 1'b1;
                        end
                        `MODE_POST_INC: begin
                            mem_req_o      <= 1'b1;
                            reg_wb_o       <= 1'b1;
                            reg_wb_value_o <= reg_value_i + step;
                        end
                        `MODE_PRE_DEC: begin
                            mem_req_o      <= 1'b1;
                            mem_write_o    <= 1'b1;
                            reg_wb_o       <= 1'b1;
                            reg_wb_value_o <= raw_addr;
                        end
                        `MODE_STACK_PUSH: begin
                            mem_req_o      <= 1'b1;
                            mem_write_o    <= 1'b1;
                            mem_word_o     <= 1'b1;
                            mem_wdata_o    <= {ccr_i, ccr_i};
                            reg_wb_o       <= 1'b1;
                            reg_wb_value_o <= aligned_addr;
                        end
                        `MODE_STACK_POP: begin
                            mem_req_o      <= 1'b1;
                            mem_word_o     <= 1'b1;
                            reg_wb_o       <= 1'b1;
                            reg_wb_value_o <= aligned_addr + 16'h0002;
                        end
                        default: begin
                            mem_req_o   <= 1'b1;
                            mem_write_o <= !is_load_i;
                        end
                    endcase
                end
            end
            // Stack pop flags come from the even (upper) byte of the word.
            if (mem_req_o && mem_ready_i && mode_i == `MODE_STACK_POP &&
                state == `ST_IDLE) begin
                ccr_load_o <= 1'b1;
                ccr_o      <= mem_rdata_i[15:8];
            end
            if (state == `ST_IND_READ && mem_ready_i) begin
                mem_req_o <= 1'b0;
                branch_o  <= 1'b1;
                done_o    <= 1'b1;
                target_o  <= {mem_rdata_i[15:1], 1'b0};
            end
        end
    end
endmodule

/* File: tb/ea_gen_asserts.sv */
// Purpose: Port-level checks for the effective address generator.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ns
`include "ea_gen_map.vh"
module ea_gen_asserts (
    input wire        clk_i,
    input wire        rst_i,
    input wire        req_i,
    input wire [4:0]  op_i,
    input wire [3:0]  mode_i,
    input wire [7:0]  byte2_i,
    input wire [7:0]  byte3_i,
    input wire [7:0]  byte4_i,
    input wire [15:0] reg_value_i,
    input wire [15:0] next_pc_i,
    input wire [7:0]  ccr_i,
    input wire        mem_ready_i,
    input wire [15:0] mem_rdata_i,
    input wire        busy_o,
    input wire        done_o,
    input wire        undefined_o,
    input wire        mem_req_o,
    input wire        mem_write_o,
    input wire [15:0] mem_addr_o,
    input wire [15:0] mem_wdata_o,
    input wire        branch_o,
    input wire [15:0] target_o,
    input wire        ccr_load_o,
    input wire [7:0]  ccr_o
);
    wire        tk = req_i && !busy_o;
    wire [15:0] dsum = reg_value_i + {byte3_i, byte4_i};
    wire [15:0] rel = next_pc_i + {{8{byte2_i[7]}}, byte2_i};
    wire [7:0]  rd_hi = mem_rdata_i[15:8];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ind_wait;
        mem_req_o && busy_o && !mem_write_o;
    endsequence
    sequence s_ind_end;
        branch_o && done_o && !mem_req_o;
    endsequence
    property p_push;
        tk && op_i == `OP_CCR_PUSH |=> mem_req_o && mem_write_o && mem_wdata_o == {2{$past(ccr_i)}};
    endproperty
    a_push: assert property (p_push) else $error("pushed flag word wrong");
    property p_pop;
        ccr_load_o |-> ccr_o == $past(rd_hi);
    endproperty
    a_pop: assert property (p_pop) else $error("restored flags wrong");
    property p_abs8;
        tk && op_i == `OP_MOVE_BYTE && mode_i == `MODE_ABS8
            |=> mem_req_o && mem_addr_o == {8'hFF, $past(byte2_i)};
    endproperty
    a_abs8: assert property (p_abs8) else $error("short absolute address wrong");
    property p_disp;
        tk && op_i == `OP_MOVE_WORD && mode_i == `MODE_DISP16
            |=> mem_req_o && mem_addr_o == ($past(dsum) & 16'hFFFE);
    endproperty
    a_disp: assert property (p_disp) else $error("displacement address wrong");
    property p_rel;
        tk && op_i == `OP_BRANCH_COND && mode_i == `MODE_PC_REL
            |=> branch_o && target_o == ($past(rel) & 16'hFFFE);
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_ind_start;
        tk && mode_i == `MODE_MEM_INDIRECT && (op_i == `OP_JUMP || op_i == `OP_JUMP_SUBROUTINE)
            |=> s_ind_wait ##0 mem_addr_o == {8'h00, $past(byte2_i) & 8'hFE};
    endproperty
    a_ind_start: assert property (p_ind_start) else $error("indirect fetch wrong");
    property p_ind_end;
        s_ind_wait ##0 mem_ready_i |=> s_ind_end ##0 target_o == ($past(mem_rdata_i) & 16'hFFFE);
    endproperty
    a_ind_end: assert property (p_ind_end) else $error("indirect target wrong");
    property p_illegal;
        tk && op_i == `OP_OTHER_ALU && mode_i != `MODE_REG_DIRECT |=> undefined_o && !mem_req_o;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal mode accepted");
endmodule

/* File: tb/ea_mem_model.sv */
// Purpose: Memory partner answering the generator's bus requests.
// Assumes: Reads return a fixed pattern of the address; writes are dropped.
// Notes:   Zero latency answers in the request cycle, as stack pops need.
`timescale 1ns/1ns
module ea_mem_model (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        req_i,
    input  wire [15:0] addr_i,
    input  wire [3:0]  lat_i,
    output wire        ready_o,
    output wire [15:0] rdata_o
);
    logic [3:0]  waited;
    logic [15:0] last;
    wire  [15:0] odd = addr_i + 16'h0001;
    // Most significant byte comes from the even address of the word.
    wire  [15:0] word = {addr_i[7:0] ^ addr_i[15:8] ^ 8'h3C, odd[7:0] ^ odd[15:8] ^ 8'h3C};
    assign ready_o = req_i && (waited >= lat_i);
    // Outside an answer the data lines show the inverse, so stale reads are caught.
    assign rdata_o = ready_o ? word : ~last;
    always @(posedge clk_i) begin
        waited <= (rst_i || !req_i || ready_o) ? 4'h0 : waited + 4'h1;
        last <= ready_o ? word : last;
    end
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the effective address generator.
// Assumes: Memory partner with adjustable answer latency.
// Notes:   Table rows cover plain modes; stack and indirect cases follow.
`timescale 1ns/1ns
`include "ea_gen_map.vh"
module tb;
    typedef struct {
        logic [4:0]  op;
        logic [3:0]  md;
        logic [7:0]  b2;
        logic [15:0] v;
        logic [1:0]  f;
        logic [15:0] ad;
        logic [2:0]  k;
        logic [15:0] x;
    } row_t;
    logic        clk_i, rst_i, req_i;
    logic [3:0]  lat;
    row_t        cur;
    int          fails = 0, checked = 0, cycles = 0, n;
    wire  [4:0]  op_i = cur.op;
    wire  [3:0]  mode_i = cur.md;
    wire         is_load_i = (cur.md != `MODE_PRE_DEC);
    wire         small_two_i = cur.b2[0];
    wire  [7:0]  byte2_i = cur.b2;
    wire  [7:0]  byte3_i = cur.v[15:8];
    wire  [7:0]  byte4_i = cur.v[7:0];
    wire  [15:0] reg_value_i = cur.v;
    wire  [15:0] next_pc_i = 16'h1000;
    wire  [7:0]  ccr_i = 8'hA7;
    wire  [15:0] stack_pointer_reg_i = 16'h3000;
    wire         bit_from_reg_i = cur.v[0];
    wire         bit_in_byte4_i = cur.b2[0];
    wire         busy_o, done_o, undefined_o, mem_req_o, mem_write_o, mem_word_o, use_reg_o;
    wire         reg_word_o, imm_valid_o, bit_num_from_reg_o, branch_o, reg_wb_o, ccr_load_o;
    wire         mem_ready_i;
    wire  [15:0] mem_addr_o, mem_wdata_o, imm_o, target_o, reg_wb_value_o, mem_rdata_i;
    wire  [2:0]  bit_num_o;
    wire  [7:0]  ccr_o;
    row_t        rows [19] = '{
        '{`OP_MOVE_BYTE, `MODE_ABS8, 8'h34, 16'h0000, 2'h2, 16'hFF34, 3'h0, 16'h0000},
        '{`OP_MOVE_WORD, `MODE_ABS16, 8'h00, 16'h1235, 2'h2, 16'h1234, 3'h0, 16'h0000},
        '{`OP_MOVE_BYTE, `MODE_REG_INDIRECT, 8'h00, 16'hABCD, 2'h2, 16'hABCD, 3'h0, 16'h0000},
        '{`OP_MOVE_WORD, `MODE_DISP16, 8'h00, 16'h1009, 2'h2, 16'h2012, 3'h0, 16'h0000},
        '{`OP_MOVE_WORD, `MODE_POST_INC, 8'h00, 16'h2000, 2'h2, 16'h2000, 3'h3, 16'h2002},
        '{`OP_MOVE_BYTE, `MODE_PRE_DEC, 8'h00, 16'h2000, 2'h2, 16'h1FFF, 3'h3, 16'h1FFF},
        '{`OP_MOVE_WORD, `MODE_IMM16, 8'h00, 16'hBEEF, 2'h0, 16'h0000, 3'h1, 16'hBEEF},
        '{`OP_ADD_BYTE, `MODE_IMM8, 8'h5A, 16'h0000, 2'h0, 16'h0000, 3'h1, 16'h005A},
        '{`OP_ADD_SMALL_CONST, `MODE_REG_DIRECT, 8'h01, 16'h0000, 2'h0, 16'h0000, 3'h1, 16'h0002},
        '{`OP_SUB_SMALL_CONST, `MODE_REG_DIRECT, 8'h00, 16'h0000, 2'h0, 16'h0000, 3'h1, 16'h0001},
        '{`OP_BRANCH_COND, `MODE_PC_REL, 8'h80, 16'h0000, 2'h0, 16'h0000, 3'h2, 16'h0F80},
        '{`OP_BRANCH_SUB, `MODE_PC_REL, 8'h7F, 16'h0000, 2'h0, 16'h0000, 3'h2, 16'h107E},
        '{`OP_BIT_SET, `MODE_REG_INDIRECT, 8'h50, 16'hABCD, 2'h2, 16'hABCD, 3'h4, 16'h0005},
        '{`OP_MUL_UNSIGNED, `MODE_REG_DIRECT, 8'h00, 16'h0000, 2'h0, 16'h0000, 3'h5, 16'h0001},
        '{`OP_ADD_BYTE, `MODE_REG_DIRECT, 8'h00, 16'h0000, 2'h0, 16'h0000, 3'h5, 16'h0000},
        '{`OP_OTHER_ALU, `MODE_ABS16, 8'h00, 16'h1234, 2'h1, 16'h0000, 3'h0, 16'h0000},
        '{`OP_MOVE_BYTE, `MODE_PC_REL, 8'h10, 16'h0000, 2'h1, 16'h0000, 3'h0, 16'h0000},
        '{`OP_MOVE_BYTE, `MODE_MEM_INDIRECT, 8'h10, 16'h0000, 2'h1, 16'h0000, 3'h0, 16'h0000},
        '{`OP_ADD_WORD, `MODE_IMM16, 8'h00, 16'h1234, 2'h1, 16'h0000, 3'h0, 16'h0000}};
    effective_address_gen DUT (.*);
    ea_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
        .lat_i(lat), .ready_o(mem_ready_i), .rdata_o(mem_rdata_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    function automatic row_t mk(input logic [4:0] op, input logic [3:0] md, input logic [7:0] b2);
        mk = '{op, md, b2, 16'h0000, 2'h0, 16'h0000, 3'h0, 16'h0000};
    endfunction
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask
    // Request rises one edge, is taken at the next, and outputs are read just after.
    task automatic issue(input row_t r);
        @(posedge clk_i);
        cur <= r;
        req_i <= 1'b1;
        @(posedge clk_i);
        req_i <= 1'b0;
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        rst_i = 1'b1;
        req_i = 1'b0;
        lat = 4'h0;
        cur = mk(`OP_MOVE_BYTE, `MODE_REG_DIRECT, 8'h00);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            issue(rows[i]);
            chk(16'(undefined_o), 16'(rows[i].f[0]));
            chk(16'(done_o), 16'h0001);
            chk(16'(mem_req_o), 16'(rows[i].f[1]));
            if (rows[i].f[1]) chk(mem_addr_o, rows[i].ad);
            case (rows[i].k)
                3'h1: chk(imm_o, rows[i].x);
                3'h2: chk(target_o, rows[i].x);
                3'h3: chk(reg_wb_value_o, rows[i].x);
                3'h4: chk(16'(bit_num_o), rows[i].x);
                3'h5: chk(16'(reg_word_o), rows[i].x);
                default: ;
            endcase
            if (rows[i].k == 3'h1) chk(16'(imm_valid_o), 16'h0001);
            if (rows[i].k == 3'h3) chk(16'(reg_wb_o), 16'h0001);
            if (rows[i].k == 3'h4) chk(16'(bit_num_from_reg_o), 16'(rows[i].v[0]));
        end
        issue(mk(`OP_CCR_PUSH, `MODE_STACK_PUSH, 8'h00));
        chk(16'(mem_write_o), 16'h0001);
        chk(mem_wdata_o, 16'hA7A7);
        chk(16'(mem_word_o), 16'h0001);
        // Bit number taken from byte 4 on a short absolute bit test.
        issue('{`OP_BIT_TEST, `MODE_ABS8, 8'h01, 16'h0070, 2'h0, 16'h0000, 3'h0, 16'h0000});
        chk(16'(bit_num_o), 16'h0007);
        chk(16'(bit_num_from_reg_o), 16'h0000);
        chk(mem_addr_o, 16'hFF01);
        issue(mk(`OP_CCR_POP, `MODE_STACK_POP, 8'h00));
        for (n = 0; n < 10 && ccr_load_o !== 1'b1; n++) step();
        chk(16'(ccr_load_o), 16'h0001);
        chk(16'(ccr_o), 16'h000C);
        // Slow and prompt answers both, from an odd low-page pointer.
        for (int j = 0; j < 2; j++) begin
            lat = j ? 4'h0 : 4'h3;
            issue(mk(j ? `OP_JUMP_SUBROUTINE : `OP_JUMP, `MODE_MEM_INDIRECT, 8'h41));
            chk(mem_addr_o, 16'h0040);
            for (n = 0; n < 10 && done_o !== 1'b1; n++) step();
            chk(16'(done_o), 16'h0001);
            chk(16'(branch_o), 16'h0001);
            chk(target_o, 16'h7C7C);
        end
        summarize();
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            summarize();
        end
    end
endmodule
bind effective_address_gen ea_gen_asserts u_chk (.*);
